/* hdl/tick_pkg.sv */
`default_nettype none
package tick_pkg;

	localparam int          DATA_WIDTH      = 32;
	localparam int          ADDR_WIDTH      = 8;
	localparam int          COUNT_WIDTH     = 24;

	// register byte offsets
	localparam logic [7:0]  OFS_CONTROL     = 8'h00;
	localparam logic [7:0]  OFS_RELOAD      = 8'h04;
	localparam logic [7:0]  OFS_CURRENT     = 8'h08;
	localparam logic [7:0]  OFS_CALIB       = 8'h0C;
	localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h10;
	localparam logic [7:0]  OFS_IRQ_MASK    = 8'h14;

	// control and status field positions
	localparam int          BIT_ENABLE      = 0;
	localparam int          BIT_EXC_ENABLE  = 1;
	localparam int          BIT_CLK_CHOICE  = 2;
	localparam int          BIT_ZERO_FLAG   = 16;

	// calibration field positions
	localparam int          BIT_NO_REF      = 31;
	localparam int          BIT_SKEW        = 30;

	// interrupt status field positions
	localparam int          BIT_IRQ_ZERO    = 0;
	localparam int          IRQ_WIDTH       = 1;

	// reset values
	localparam logic [23:0] RESET_COUNT     = 24'h000000;
	localparam logic        RESET_CLK_CHOICE = 1'b1;

	// calibration defaults: ten millisecond reload at 100 MHz
	localparam int          CLOCK_HZ        = 100000000;
	localparam int          TEN_MS_US       = 10000;
	localparam int          TEN_MS_CYCLES   = CLOCK_HZ / 1000000 * TEN_MS_US - 1;

	typedef struct packed {
		logic       enable;
		logic       exc_enable;
		logic       clk_choice;
	} control_type;

	typedef struct packed {
		logic                  no_reference_clock;
		logic                  skew_inexact;
		logic [23:0]           ten_millisecond_count;
	} calib_type;

endpackage
`default_nettype wire

/* hdl/tick_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module tick_sync (
	input  wire logic clk_sys_i,
	input  wire logic resetn_i,
	input  wire logic async_i,
	output logic      sync_o
);
	logic stage1;

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			stage1 <= 1'b0;
			sync_o <= 1'b0;
		end else begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule // tick_sync
`default_nettype wire

/* hdl/system_tick_timer.sv */
// How it works
// - reload field copied into counter when enabled and at each zero.
// - reload of zero never sets flag nor requests the exception.
// - current-value read returns live 24-bit counter.
// - any current-value write zeroes counter and clears zero flag, unless a zero step sets it in the same cycle.
// - calibration bit 31 is one when no reference clock exists.
// - calibration bit 30 is one when ten ms count is inexact.
// - low 24 calibration bits hold ten ms reload, zero means unknown.
// - counting freezes while the counter clock is stopped.
// - control bits: enable, exception enable, clock choice, zero flag.
// - at zero set flag, request exception if enabled, reload, continue.
// - decrement once per tick, wrap to reload after zero.
// - counter holds while the processor is halted for debug.
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module system_tick_timer
	import tick_pkg::*;
#(
	parameter logic        HAS_REF_CLOCK = 1'b1,
	parameter logic        TEN_MS_EXACT  = 1'b0,
	parameter logic [23:0] TEN_MS_VALUE  = 24'(TEN_MS_CYCLES)
) (
	input  wire logic                  clk_sys_i,
	input  wire logic                  resetn_i,
	input  wire logic [ADDR_WIDTH-1:0] addr_i,
	input  wire logic [DATA_WIDTH-1:0] wdata_i,
	input  wire logic                  write_i,
	input  wire logic                  read_i,
	output logic      [DATA_WIDTH-1:0] rdata_o,
	input  wire logic                  ref_clock_i,
	input  wire logic                  debug_halt_i,
	input  wire logic                  clock_stopped_i,
	output logic                       tick_request_o,
	output logic                       irq_o
);

	control_type              control;
	logic [COUNT_WIDTH-1:0]   reload;
	logic [COUNT_WIDTH-1:0]   count;
	logic                     zero_reached_flag;
	logic                     enable_seen;
	logic                     ref_sync;
	logic                     ref_last;
	logic [IRQ_WIDTH-1:0]     irq_status;
	logic [IRQ_WIDTH-1:0]     irq_mask;

	// the only counting step that raises events
	function automatic logic last_step(input logic [COUNT_WIDTH-1:0] c);
		return c == COUNT_WIDTH'(1);
	endfunction

	// reference clock is a pin: synchronise, then detect rising edges
	tick_sync ref_sync_inst (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.async_i   (ref_clock_i),
		.sync_o    (ref_sync)
	);

	wire sel_control = (addr_i == OFS_CONTROL);
	wire sel_reload  = (addr_i == OFS_RELOAD);
	wire sel_current = (addr_i == OFS_CURRENT);
	wire sel_calib   = (addr_i == OFS_CALIB);
	wire sel_status  = (addr_i == OFS_IRQ_STATUS);
	wire sel_mask    = (addr_i == OFS_IRQ_MASK);

	wire wr_control  = write_i && sel_control;
	wire wr_reload   = write_i && sel_reload;
	wire wr_current  = write_i && sel_current;
	wire wr_mask     = write_i && sel_mask;
	wire rd_control  = read_i && sel_control;
	wire rd_status   = read_i && sel_status;

	wire ref_edge    = ref_sync && !ref_last;

	// processor clock or reference edges; debug halt and a stopped clock
	// both freeze the counter
	wire tick_src    = control.clk_choice ? 1'b1 : ref_edge;
	wire tick        = control.enable && tick_src
	                   && !debug_halt_i && !clock_stopped_i;

	wire first_load  = control.enable && !enable_seen;
	// the step from one to zero is the only event
	wire hit_zero    = tick && !first_load
	                   && last_step(count);

	wire [COUNT_WIDTH-1:0] next_count =
		wr_current ? RESET_COUNT :
		first_load ? reload :
		!tick      ? count :
		(count == RESET_COUNT) ? reload :
		count - 24'h000001;

	// set wins over a clearing read of the same cycle
	wire next_zero_flag = hit_zero
	                      || (zero_reached_flag
	                          && !rd_control && !wr_current);

	wire next_clk_choice = !HAS_REF_CLOCK ? 1'b1 :
	                       wr_control ? wdata_i[BIT_CLK_CHOICE] :
	                       control.clk_choice;

	wire [IRQ_WIDTH-1:0] next_irq_status =
		(rd_status ? '0 : irq_status) | IRQ_WIDTH'(hit_zero);

	calib_type calib;
	// one assignment keeps the whole struct on a single driver
	assign calib = {!HAS_REF_CLOCK, !TEN_MS_EXACT,
	                TEN_MS_VALUE};

	wire [DATA_WIDTH-1:0] control_word =
		{15'h0000, zero_reached_flag, 13'h0000, control.clk_choice,
		 control.exc_enable, control.enable};

	wire [DATA_WIDTH-1:0] read_word =
		sel_control ? control_word :
		sel_reload  ? {8'h00, reload} :
		sel_current ? {8'h00, count} :
		sel_calib   ? {calib[25:24], 6'h00, calib[23:0]} :
		sel_status  ? {31'h00000000, irq_status} :
		sel_mask    ? {31'h00000000, irq_mask} :
		32'h00000000;

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			control.enable     <= 1'b0;
			control.exc_enable <= 1'b0;
			control.clk_choice <= RESET_CLK_CHOICE;
			enable_seen        <= 1'b0;
			ref_last           <= 1'b0;
		end else begin
			if (wr_control) begin
				control.enable     <= wdata_i[BIT_ENABLE];
				control.exc_enable <= wdata_i[BIT_EXC_ENABLE];
			end
			control.clk_choice <= next_clk_choice;
			enable_seen        <= control.enable;
			ref_last           <= ref_sync;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			reload            <= RESET_COUNT;
			count             <= RESET_COUNT;
			zero_reached_flag <= 1'b0;
		end else begin
			if (wr_reload)
				reload <= wdata_i[COUNT_WIDTH-1:0];
			count             <= next_count;
			zero_reached_flag <= next_zero_flag;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			irq_status     <= '0;
			irq_mask       <= '0;
			rdata_o        <= 32'h00000000;
			tick_request_o <= 1'b0;
			irq_o          <= 1'b0;
		end else begin
			irq_status     <= next_irq_status;
			if (wr_mask)
				irq_mask <= wdata_i[IRQ_WIDTH-1:0];
			rdata_o        <= read_i ? read_word : 32'h00000000;
			tick_request_o <= hit_zero && control.exc_enable;
			irq_o          <= |(next_irq_status & irq_mask);
		end
	end

	// interrupt line mirrors a masked sticky bit on the same edge that sets it
	sequence s_zero_step;
		tick && !first_load && last_step(count);
	endsequence

	chk_zero_sets_flag: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		s_zero_step |=> zero_reached_flag)
		else $error("zero step did not set flag");

	chk_request_gated: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		s_zero_step |=> (tick_request_o == $past(control.exc_enable)))
		else $error("exception request not gated by enable");

	chk_no_spurious_req: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		tick_request_o |-> $past(count) == 24'h000001)
		else $error("request without one to zero step");

	// a zero step in the clearing cycle still sets the flag
	chk_current_clear: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		wr_current |=> count == 24'h000000
		&& zero_reached_flag == $past(hit_zero))
		else $error("current write did not clear");

	chk_wrap_reload: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		tick && !first_load && !wr_current && count == 24'h000000
		|=> count == $past(reload))
		else $error("counter did not wrap to reload");

	chk_decrement_one: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		tick && !first_load && !wr_current && count != 24'h000000
		|=> count == $past(count) - 24'h000001)
		else $error("counter did not step by one");

	chk_halt_holds: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		(debug_halt_i || clock_stopped_i) && !wr_current
		&& !first_load |=> $stable(count))
		else $error("counter moved while frozen");

	chk_enable_loads: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		first_load && !wr_current |=> count == $past(reload))
		else $error("enable did not load reload");

	chk_no_reference_clock_choice: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		!HAS_REF_CLOCK |=> control.clk_choice)
		else $error("clock choice not forced to one");

	chk_current_read: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		read_i && sel_current |=> rdata_o == {8'h00, $past(count)})
		else $error("current read wrong");

	chk_calib_read: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		read_i && sel_calib |=> rdata_o[31] == !HAS_REF_CLOCK
		&& rdata_o[30] == !TEN_MS_EXACT
		&& rdata_o[29:24] == 6'h00 && rdata_o[23:0] == TEN_MS_VALUE)
		else $error("calibration read wrong");

	chk_reload_read: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		read_i && sel_reload |=> rdata_o == {8'h00, $past(reload)})
		else $error("reload read wrong");

	chk_control_read: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		read_i && sel_control |=> rdata_o[31:17] == 15'h0000
		&& rdata_o[15:3] == 13'h0000
		&& rdata_o[16] == $past(zero_reached_flag))
		else $error("control read wrong");

	chk_rdata_idle: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		!read_i |=> rdata_o == 32'h00000000)
		else $error("read data outside a read cycle");

	chk_flag_read_clear: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		rd_control && !hit_zero |=> !zero_reached_flag)
		else $error("control read did not clear flag");

	chk_zero_reload_idle: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		tick && !wr_current && count == 24'h000000 && reload == 24'h000000
		|=> count == 24'h000000 && !tick_request_o)
		else $error("zero reload left zero");

	chk_request_pulse: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		tick_request_o |=> !tick_request_o)
		else $error("exception request longer than one cycle");

	chk_status_sticky: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		hit_zero |=> irq_status[BIT_IRQ_ZERO])
		else $error("zero step did not set status");

	chk_status_clear: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		rd_status && !hit_zero |=> irq_status == '0)
		else $error("status read did not clear");

	chk_irq_level: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		!wr_mask |=> irq_o == |(irq_status & irq_mask))
		else $error("interrupt line does not follow status");

	chk_disabled_holds: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		!control.enable && !wr_current |=> $stable(count))
		else $error("disabled counter moved");

	chk_ref_paced: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		control.enable && !control.clk_choice && !ref_edge
		&& !wr_current && !first_load |=> $stable(count))
		else $error("counter moved without reference edge");

	chk_choice_write: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		HAS_REF_CLOCK && wr_control
		|=> control.clk_choice == $past(wdata_i[BIT_CLK_CHOICE]))
		else $error("clock choice write lost");

	chk_mask_write: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i)
		wr_mask |=> irq_mask == $past(wdata_i[IRQ_WIDTH-1:0]))
		else $error("mask write lost");

endmodule // system_tick_timer
`default_nettype wire

/* verification/system_tick_timer_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module system_tick_timer_tb_top;
	import tick_pkg::*;
	localparam logic [23:0]    TEN_MS_RELOAD = 24'h0F423F;
	logic                      clk_sys_i;
	logic                      resetn_i;
	logic                      write_i;
	logic                      read_i;
	logic                      ref_clock_i = 1'b0;
	logic                      debug_halt_i;
	logic                      clock_stopped_i;
	logic                      tick_request_o;
	logic                      irq_o;
	logic [ADDR_WIDTH-1:0]     addr_i;
	logic [DATA_WIDTH-1:0]     wdata_i;
	logic [DATA_WIDTH-1:0]     rdata_o;
	logic [DATA_WIDTH-1:0]     rdata_no_reference_clock;
	logic [31:0]               v;
	logic [31:0]               w;
	logic [31:0]               lfsr;
	logic [2:0]                rc = 3'h0;
	logic                      ref_run;
	int                        bad_count;
	int                        samples_checked;
	int                        t0;
	int                        t1;
	int                        rt;
	int                        n;
	int                        d;

	system_tick_timer #(.HAS_REF_CLOCK(1'b1), .TEN_MS_EXACT(1'b0),
		.TEN_MS_VALUE(TEN_MS_RELOAD)) u_dut (.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
		.ref_clock_i(ref_clock_i), .debug_halt_i(debug_halt_i),
		.clock_stopped_i(clock_stopped_i),
		.tick_request_o(tick_request_o), .irq_o(irq_o));

	// a variant without reference clock, fed the same bus traffic
	system_tick_timer #(.HAS_REF_CLOCK(1'b0), .TEN_MS_EXACT(1'b1),
		.TEN_MS_VALUE(TEN_MS_RELOAD)) u_dut_no_reference_clock (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.write_i(write_i), .read_i(read_i), .rdata_o(rdata_no_reference_clock),
		.ref_clock_i(1'b0), .debug_halt_i(debug_halt_i),
		.clock_stopped_i(clock_stopped_i),
		.tick_request_o(), .irq_o());

	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	// reference clock with an eight cycle period, derived from the bus clock
	always @(posedge clk_sys_i) begin
		rc <= rc + 3'h1;
		ref_clock_i <= ref_run & rc[2];
	end

	function automatic logic [31:0] next_rand();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction

	function automatic logic [31:0] exp_reload(input logic [31:0] r);
		return {8'h00, r[23:0]};
	endfunction

	// one tick per cycle: the period is one longer than the reload
	function automatic logic [31:0] exp_period(input logic [31:0] r);
		return exp_reload(r) + 32'h00000001;
	endfunction

	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t word got %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_flag(input logic g, input logic e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t flag got %b expected %b", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= dat;
		write_i <= 1'b1;
		@(posedge clk_sys_i);
		write_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] dat);
		@(posedge clk_sys_i);
		addr_i <= a;
		read_i <= 1'b1;
		@(posedge clk_sys_i);
		read_i <= 1'b0;
		rt = int'($time / 10);
		#1 dat = rdata_o;
	endtask

	task automatic wait_tick(output int t);
		t = 0;
		for (int i = 0; i < 3000 && t == 0; i++) begin
			@(posedge clk_sys_i);
			#1;
			if (tick_request_o === 1'b1) t = int'($time / 10);
		end
		if (t == 0) begin
			bad_count++;
			$display("ERROR %0t no exception request seen", $time);
		end
	endtask

	task automatic quiet(input int c);
		repeat (c) begin
			@(posedge clk_sys_i);
			#1 chk_flag(tick_request_o, 1'b0);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		bad_count++;
		wrap_up();
	end

	initial begin
		{resetn_i, write_i, read_i, debug_halt_i, clock_stopped_i} = 5'h00;
		{addr_i, wdata_i, ref_run} = '0;
		{bad_count, samples_checked} = '0;
		lfsr = 32'h0000001B;
		repeat (3) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		rd(OFS_CONTROL, v);
		chk_word(v, 32'h00000004);
		chk_word(rdata_no_reference_clock, 32'h00000004);
		wr(OFS_CALIB, 32'h00000000);
		rd(OFS_CALIB, v);
		chk_word(v, {2'b01, 6'h00, TEN_MS_RELOAD});
		chk_word(rdata_no_reference_clock, {2'b10, 6'h00, TEN_MS_RELOAD});
		rd(8'h18, v);
		chk_word(v, 32'h00000000);
		for (n = 0; n < 4; n++) begin
			w = next_rand();
			wr(OFS_RELOAD, w);
			rd(OFS_RELOAD, v);
			chk_word(v, exp_reload(w));
		end
		$display("test registers done");
		wr(OFS_IRQ_MASK, 32'h00000001);
		for (n = 0; n < 4; n++) begin
			// shortest legal reload first: a pulse every other cycle
			w = (n == 0) ? 32'h00000001 : (next_rand() % 40) + 2;
			wr(OFS_RELOAD, w);
			wr(OFS_CURRENT, next_rand());
			wr(OFS_CONTROL, 32'h00000007);
			wait_tick(t0);
			wait_tick(t1);
			chk_word(32'(t1 - t0), exp_period(w));
		end
		// stop counting but keep the processor clock chosen
		wr(OFS_CONTROL, 32'h00000004);
		repeat (3) @(posedge clk_sys_i);
		#1 chk_flag(irq_o, 1'b1);
		rd(OFS_IRQ_STATUS, v);
		chk_word(v, 32'h00000001);
		rd(OFS_CONTROL, v);
		chk_word(v, 32'h00010004);
		rd(OFS_CONTROL, v);
		chk_word(v, 32'h00000004);
		rd(OFS_IRQ_STATUS, v);
		chk_word(v, 32'h00000000);
		chk_flag(irq_o, 1'b0);
		$display("test period done");
		wr(OFS_IRQ_MASK, 32'h00000000);
		wr(OFS_RELOAD, 32'h00000005);
		wr(OFS_CURRENT, 32'h00000000);
		wr(OFS_CONTROL, 32'h00000005);
		quiet(20);
		wr(OFS_CONTROL, 32'h00000004);
		rd(OFS_IRQ_STATUS, v);
		chk_word(v, 32'h00000001);
		chk_flag(irq_o, 1'b0);
		wr(OFS_RELOAD, 32'h00000000);
		wr(OFS_CURRENT, 32'h00000001);
		wr(OFS_CONTROL, 32'h00000007);
		quiet(30);
		rd(OFS_CONTROL, v);
		chk_word(v, 32'h00000007);
		$display("test events done");
		wr(OFS_RELOAD, 32'h00FFFFFF);
		wr(OFS_CURRENT, 32'h00000000);
		wr(OFS_CONTROL, 32'h00000005);
		repeat (2) @(posedge clk_sys_i);
		rd(OFS_CURRENT, v);
		t0 = rt;
		repeat (8) @(posedge clk_sys_i);
		rd(OFS_CURRENT, w);
		chk_word(v - w, 32'(rt - t0));
		for (n = 0; n < 2; n++) begin
			@(posedge clk_sys_i);
			debug_halt_i <= (n == 0);
			clock_stopped_i <= (n == 1);
			rd(OFS_CURRENT, v);
			repeat (5) @(posedge clk_sys_i);
			rd(OFS_CURRENT, w);
			chk_word(w, v);
		end
		wr(OFS_CURRENT, next_rand());
		rd(OFS_CURRENT, v);
		chk_word(v, 32'h00000000);
		@(posedge clk_sys_i);
		{debug_halt_i, clock_stopped_i} <= 2'b00;
		$display("test counting done");
		wr(OFS_CONTROL, 32'h00000001);
		ref_run <= 1'b1;
		rd(OFS_CONTROL, v);
		chk_word(v & 32'h00000007, 32'h00000001);
		chk_word(rdata_no_reference_clock & 32'h00000007, 32'h00000005);
		rd(OFS_CURRENT, v);
		t0 = rt;
		repeat (40) @(posedge clk_sys_i);
		rd(OFS_CURRENT, w);
		d = (rt - t0) / 8;
		n = int'(v - w);
		chk_flag(n >= d - 1 && n <= d + 1, 1'b1);
		$display("test reference clock done");
		wrap_up();
	end
endmodule // system_tick_timer_tb_top
`default_nettype wire
